// ---- adc_pkg.sv ----
// constants and types shared by the converter control block
// assumes one system clock domain plus the serial clock of the host port
package adc_pkg;
    localparam int NOM_CLK_HZ = 7372800; // nominal modulator clock
    localparam int MAIN_W = 32;
    localparam int AUX_W = 24;
    localparam int FRAME_W = 48;
    localparam int ST_OVR_POS = 40;
    localparam int ST_REF_POS = 41;
    localparam logic [7:0] MAIN_SEL_ADDR = 8'h06;
    localparam logic [7:0] AUX_SEL_ADDR = 8'h16;
    localparam logic [7:0] CMD_START = 8'h08;
    localparam logic [7:0] CMD_STOP = 8'h0a;
    localparam logic [7:0] CMD_RD_MAIN = 8'h12;
    localparam logic [7:0] CMD_RD_AUX = 8'h14;
    localparam logic [5:0] CMD_LAST = 6'h07;
    localparam logic [5:0] SHF_LAST = 6'h2f;
    localparam logic [2:0] GAIN_MAX = 3'h5;
    localparam logic [2:0] FLT_SINC1 = 3'h0;
    localparam logic [2:0] FLT_FIR = 3'h4;
    localparam logic [3:0] RATE_20SPS = 4'h4;
    localparam logic [1:0] CLK_INT = 2'h0;
    localparam logic [1:0] CLK_XTAL = 2'h1;
    localparam logic [1:0] CLK_EXT = 2'h2;
    localparam logic [7:0] CRC_INIT = 8'hff;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam int A_START = 0;
    localparam int A_RP = 1;
    localparam int A_XT = 2;
    localparam int A_EC = 3;
    localparam int A_OVR = 4;
    localparam int A_REF = 5;
    localparam logic [5:0] A_IDLE = 6'h02;
    localparam int T_START = 0;
    localparam int T_STOP = 1;
    localparam int T_READ = 2;
    localparam int CLK_PERIOD_NS = 50;
    localparam int PWDN_HOLD_NS = 1000;
    localparam int PWDN_CYC = (PWDN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PCW = $clog2(PWDN_CYC + 1);
    localparam logic [PCW-1:0] PWDN_CNT = PCW'(PWDN_CYC);
    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_PWDN} conv_st_t;
endpackage

// ---- adc_ctrl.sv ----
// converter control: config, conversion sequencing, result framing, host port
// assumes analog core strobes results on i_clk; alarms and pins are async
`timescale 1ns/10ps

// What this block does
// RULE_01: main results are 32 bits, rates coded
// RULE_02: gain one to thirty-two, plus bypass
// RULE_03: overrange latched per conversion, sent with result
// RULE_04: reference alarm latched per conversion, sent too
// RULE_05: sinc filter order one to four
// RULE_06: fir only at twenty samples per second; code also keeps fir at the rate codes below RATE_20SPS
// RULE_07: aux results 24 bits, gain to 128
// RULE_08: port uses select, clock, data in, out
// RULE_09: every result carries a crc byte
// RULE_10: output pin shows ready, then data bits
// RULE_11: host may tie select low, framing by count
// RULE_12: clock source chosen automatically, nominal frequency
// RULE_13: start by pin or serial command
// RULE_14: free-run or one conversion per start
// RULE_15: new result drives both ready pins low
// RULE_16: reset pin pulse resets, held low powers down
// RULE_17: any input to either converter mux
// RULE_18: eight gpio on analog pins three-nine, common
// RULE_19: input select fields, positive and negative nibbles
// RULE_20: ready goes high on read or update
module adc_ctrl (
    input  wire logic                         i_clk,
    input  wire logic                         i_rst,
    input  wire logic                         i_clk_en,
    input  wire logic                         i_sclk,
    input  wire logic                         i_cs_n,
    input  wire logic                         i_din,
    input  wire logic                         i_start,
    input  wire logic                         i_reset_powerdown_pin_n,
    input  wire logic                         i_xtal_det,
    input  wire logic                         i_ext_clk_det,
    input  wire logic                         i_overrange,
    input  wire logic                         i_ref_alarm,
    input  wire logic                         i_main_done,
    input  wire logic [adc_pkg::MAIN_W-1:0]   i_main_result,
    input  wire logic                         i_aux_en,
    input  wire logic                         i_aux_done,
    input  wire logic [adc_pkg::AUX_W-1:0]    i_aux_result,
    input  wire logic                         i_oneshot,
    input  wire logic [2:0]                   i_gain,
    input  wire logic                         i_pga_bypass,
    input  wire logic [2:0]                   i_filter,
    input  wire logic [3:0]                   i_rate,
    input  wire logic [2:0]                   i_aux_gain,
    input  wire logic [3:0]                   i_main_positive_input_field,
    input  wire logic [3:0]                   i_main_negative_input_field,
    input  wire logic [3:0]                   i_aux_positive_input_field,
    input  wire logic [3:0]                   i_aux_negative_input_field,
    input  wire logic [7:0]                   i_gpio_dir,
    input  wire logic [7:0]                   i_gpio_out,
    input  wire logic [7:0]                   i_gpio_pin,
    output logic                              o_serial_out_ready_pin,
    output logic                              o_conversion_ready_n,
    output logic                              o_converting,
    output logic                              o_powerdown,
    output logic [1:0]                        o_clk_source,
    output logic [2:0]                        o_pga_gain,
    output logic                              o_pga_bypass,
    output logic [2:0]                        o_filter,
    output logic                              o_filter_fallback,
    output logic [3:0]                        o_rate,
    output logic [2:0]                        o_aux_gain,
    output logic [7:0]                        o_main_input_select,
    output logic [7:0]                        o_aux_input_select,
    output logic [7:0]                        o_gpio_oe,
    output logic [7:0]                        o_gpio_drive,
    output logic [7:0]                        o_gpio_in
);
    import adc_pkg::*;

    typedef struct packed {
        conv_st_t               st;
        logic                   rdy_n;
        logic                   ld_pend;
        logic                   ovr;
        logic                   refa;
        logic                   pwdn;
        logic                   fb;
        logic                   byp;
        logic [FRAME_W-1:0]     tx_m;
        logic [FRAME_W-1:0]     tx_a;
        logic [PCW-1:0]         rp_cnt;
        logic [2:0]             gain;
        logic [2:0]             again;
        logic [2:0]             filt;
        logic [3:0]             rate;
        logic [7:0]             msel;
        logic [7:0]             asel;
        logic [7:0]             gpo;
        logic [7:0]             gpoe;
        logic [7:0]             gpi_s1;
        logic [7:0]             gpi_s2;
        logic [1:0]             csrc;
        logic [5:0]             a_s1;
        logic [5:0]             a_s2;
        logic                   st_d;
        logic [2:0]             lt_s1;
        logic [2:0]             lt_s2;
        logic [2:0]             lt_d;
    } sys_t;

    typedef struct packed {
        logic                   rd;
        logic [5:0]             cnt;
        logic [7:0]             cmd;
        logic [FRAME_W-1:0]     shf;
    } frm_t;

    typedef struct packed {
        logic [2:0]             tog;
    } tog_t;

    sys_t s;
    sys_t s_next;
    frm_t f;
    frm_t f_next;
    tog_t t;
    tog_t t_next;
    logic start_ev;
    logic stop_ev;
    logic [7:0] stat;
    logic [7:0] cmdv;
    logic [2:0] fire;
    logic frm_rst;

    function automatic logic [7:0] crc8(input logic [39:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 39; i >= 0; i--) begin
            c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    always_comb begin
        s_next = s;
        s_next.a_s1 = {i_ref_alarm, i_overrange, i_ext_clk_det, i_xtal_det,
                       i_reset_powerdown_pin_n, i_start};
        s_next.a_s2 = s.a_s1;
        s_next.gpi_s1 = i_gpio_pin;
        s_next.gpi_s2 = s.gpi_s1;
        s_next.lt_s1 = t.tog;
        s_next.lt_s2 = s.lt_s1;
        s_next.lt_d = s.lt_s2;
        s_next.st_d = s.a_s2[A_START];
        s_next.ld_pend = 1'b0;
        // out-of-range gain codes clamp rather than wrap
        s_next.gain = (i_gain > GAIN_MAX) ? GAIN_MAX : i_gain; // RULE_02
        s_next.byp = i_pga_bypass; // RULE_02
        s_next.again = i_aux_gain; // RULE_07
        s_next.rate = i_rate; // RULE_01
        // fir above its rate limit would not settle in one period
        s_next.fb = (i_filter > FLT_FIR) || (i_filter == FLT_FIR && i_rate > RATE_20SPS); // RULE_06
        s_next.filt = s_next.fb ? FLT_SINC1 : i_filter; // RULE_05
        s_next.msel = {i_main_positive_input_field, i_main_negative_input_field}; // RULE_19
        s_next.asel = {i_aux_positive_input_field, i_aux_negative_input_field}; // RULE_17
        // bit k sits on analog pin k+3, bit 7 on the common input
        s_next.gpoe = i_gpio_dir; // RULE_18
        s_next.gpo = i_gpio_out & i_gpio_dir; // RULE_18
        s_next.csrc = s.a_s2[A_EC] ? CLK_EXT : (s.a_s2[A_XT] ? CLK_XTAL : CLK_INT); // RULE_12
        start_ev = (s.a_s2[A_START] & ~s.st_d) | (s.lt_s2[T_START] ^ s.lt_d[T_START]); // RULE_13
        stop_ev = s.lt_s2[T_STOP] ^ s.lt_d[T_STOP];
        stat = {6'h00, s.refa | s.a_s2[A_REF], s.ovr | s.a_s2[A_OVR]};
        if (s.lt_s2[T_READ] ^ s.lt_d[T_READ]) begin
            s_next.rdy_n = 1'b1; // RULE_20
        end
        if (s.ld_pend) begin
            s_next.rdy_n = 1'b0; // RULE_15
        end
        if (i_aux_en && i_aux_done) begin
            s_next.tx_a = {stat, i_aux_result, 8'h00, crc8({stat, i_aux_result, 8'h00})}; // RULE_07
        end
        case (s.st)
            ST_IDLE: begin
                if (start_ev) begin
                    s_next.st = ST_CONV; // RULE_13
                    s_next.ovr = s.a_s2[A_OVR];
                    s_next.refa = s.a_s2[A_REF];
                end
            end
            ST_CONV: begin
                s_next.ovr = s.ovr | s.a_s2[A_OVR]; // RULE_03
                s_next.refa = s.refa | s.a_s2[A_REF]; // RULE_04
                if (i_main_done) begin
                    s_next.tx_m = {stat, i_main_result, crc8({stat, i_main_result})}; // RULE_09
                    s_next.rdy_n = 1'b1; // RULE_20
                    s_next.ld_pend = 1'b1;
                    s_next.ovr = s.a_s2[A_OVR];
                    s_next.refa = s.a_s2[A_REF];
                    if (i_oneshot) begin
                        s_next.st = ST_IDLE; // RULE_14
                    end
                end
                if (stop_ev) begin
                    s_next.st = ST_IDLE;
                end
            end
            ST_PWDN: begin
                s_next.st = ST_PWDN;
            end
            default: begin
                s_next.st = ST_IDLE;
            end
        endcase
        // any low level is a reset; a long one also powers down
        if (!s.a_s2[A_RP]) begin
            s_next.st = ST_PWDN; // RULE_16
            s_next.rdy_n = 1'b1;
            s_next.ld_pend = 1'b0;
            s_next.ovr = 1'b0;
            s_next.refa = 1'b0;
            s_next.rp_cnt = (s.rp_cnt == PWDN_CNT) ? s.rp_cnt : s.rp_cnt + 1'b1;
            s_next.pwdn = (s_next.rp_cnt == PWDN_CNT); // RULE_16
        end else begin
            s_next.rp_cnt = '0;
            s_next.pwdn = 1'b0;
            if (s.st == ST_PWDN) begin
                s_next.st = ST_IDLE;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s <= '0;
            s.rdy_n <= 1'b1;
            s.a_s1 <= A_IDLE;
            s.a_s2 <= A_IDLE;
        end else if (i_clk_en) begin
            s <= s_next;
        end
    end

    // serial side: command byte, then 48 bits out for a read
    // tx words are read quasi-static; a read racing an update may mix words
    assign frm_rst = i_rst | i_cs_n; // RULE_08

    always_comb begin
        f_next = f;
        fire = 3'h0;
        cmdv = {f.cmd[6:0], i_din};
        if (!f.rd) begin
            f_next.cmd = cmdv;
            f_next.cnt = f.cnt + 6'h01;
            if (f.cnt == CMD_LAST) begin
                f_next.cnt = 6'h00; // RULE_11
                case (cmdv)
                    CMD_START: fire[T_START] = 1'b1; // RULE_13
                    CMD_STOP: fire[T_STOP] = 1'b1;
                    CMD_RD_MAIN: begin
                        f_next.rd = 1'b1; // RULE_10
                        f_next.shf = s.tx_m;
                        fire[T_READ] = 1'b1;
                    end
                    CMD_RD_AUX: begin
                        f_next.rd = 1'b1;
                        f_next.shf = s.tx_a;
                    end
                    default: begin
                        f_next.rd = 1'b0;
                    end
                endcase
            end
        end else begin
            f_next.shf = {f.shf[FRAME_W-2:0], 1'b0}; // RULE_10
            f_next.cnt = f.cnt + 6'h01;
            if (f.cnt == SHF_LAST) begin
                f_next.rd = 1'b0; // RULE_11
                f_next.cnt = 6'h00;
            end
        end
        t_next.tog = t.tog ^ fire;
    end

    always_ff @(posedge i_sclk or posedge frm_rst) begin
        if (frm_rst) begin
            f <= '0;
        end else begin
            f <= f_next;
        end
    end

    // toggles survive deselect so no event is lost
    always_ff @(posedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            t <= '0;
        end else begin
            t <= t_next;
        end
    end

    assign o_serial_out_ready_pin = f.rd ? f.shf[FRAME_W-1] : s.rdy_n; // RULE_10
    assign o_conversion_ready_n = s.rdy_n;
    assign o_converting = (s.st == ST_CONV);
    assign o_powerdown = s.pwdn;
    assign o_clk_source = s.csrc;
    assign o_pga_gain = s.gain;
    assign o_pga_bypass = s.byp;
    assign o_filter = s.filt;
    assign o_filter_fallback = s.fb;
    assign o_rate = s.rate;
    assign o_aux_gain = s.again;
    assign o_main_input_select = s.msel;
    assign o_aux_input_select = s.asel;
    assign o_gpio_oe = s.gpoe;
    assign o_gpio_drive = s.gpo;
    assign o_gpio_in = s.gpi_s2;

    rdy_high_a: assert property (@(posedge i_clk) disable iff (i_rst || !i_clk_en || !s.a_s2[A_RP]) // RULE_20
        (s.st == ST_CONV && i_main_done) |=> o_conversion_ready_n) else $error("ready not raised");
    rdy_low_a: assert property (@(posedge i_clk) disable iff (i_rst || !i_clk_en || !s.a_s2[A_RP]) // RULE_15
        (s.st == ST_CONV && i_main_done) ##1 !i_main_done |=> !o_conversion_ready_n) else $error("ready not low");
    ovr_flag_a: assert property (@(posedge i_clk) disable iff (i_rst || !i_clk_en || !s.a_s2[A_RP]) // RULE_03
        (s.st == ST_CONV && i_main_done && s.a_s2[A_OVR]) |=> s.tx_m[ST_OVR_POS]) else $error("overrange lost");
    ref_flag_a: assert property (@(posedge i_clk) disable iff (i_rst || !i_clk_en || !s.a_s2[A_RP]) // RULE_04
        (s.st == ST_CONV && i_main_done && s.a_s2[A_REF]) |=> s.tx_m[ST_REF_POS]) else $error("ref alarm lost");
    crc_ok_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_09
        s.ld_pend |-> s.tx_m[7:0] == crc8(s.tx_m[FRAME_W-1:8])) else $error("bad crc");
    gain_cap_a: assert property (@(posedge i_clk) disable iff (i_rst || !i_clk_en) // RULE_02
        (i_gain > GAIN_MAX) |=> o_pga_gain == GAIN_MAX) else $error("gain not clamped");
    fir_lim_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_06
        o_filter == FLT_FIR |-> o_rate <= RATE_20SPS) else $error("fir above rate");
    one_shot_a: assert property (@(posedge i_clk) disable iff (i_rst || !i_clk_en || !s.a_s2[A_RP]) // RULE_14
        (s.st == ST_CONV && i_main_done && i_oneshot) |=> s.st == ST_IDLE) else $error("oneshot ran on");
    start_go_a: assert property (@(posedge i_clk) disable iff (i_rst || !i_clk_en || !s.a_s2[A_RP]) // RULE_13
        (s.st == ST_IDLE && start_ev) |=> o_converting) else $error("start ignored");
    pwdn_hold_a: assert property (@(posedge i_clk) disable iff (i_rst || !i_clk_en) // RULE_16
        (!s.a_s2[A_RP] && s.rp_cnt == PWDN_CNT - 1'b1) |=> o_powerdown) else $error("no powerdown");
    clk_sel_a: assert property (@(posedge i_clk) disable iff (i_rst || !i_clk_en) // RULE_12
        s.a_s2[A_EC] |=> o_clk_source == CLK_EXT) else $error("ext clock not chosen");

    one_conv_c: cover property (@(posedge i_clk) s.st == ST_CONV && i_main_done && i_oneshot);
    free_run_c: cover property (@(posedge i_clk) s.ld_pend ##[1:200] s.ld_pend);
    host_read_c: cover property (@(posedge i_clk) s.lt_s2[T_READ] != s.lt_d[T_READ]);
    pwdn_c: cover property (@(posedge i_clk) o_powerdown);
endmodule

// ---- host_spi.sv ----
// host serial controller model: sends commands and reads frames over the four-wire port
// assumes the caller spaces frames; the serial clock idles low between frames
`timescale 1ns/10ps
module host_spi (
    input  wire logic        i_pin,
    output logic             o_sclk,
    output logic             o_cs_n,
    output logic             o_din,
    output logic [47:0]      o_word,
    output logic             o_word_vld
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_din = 1'b0;
        o_word = '0;
        o_word_vld = 1'b0;
    end

    // three-wire mode leaves select low, so framing rests on bit counts alone
    task automatic frame(input logic [7:0] cmd, input logic rd, input logic tw);
        int n;
        n = rd ? 56 : 8;
        o_cs_n = 1'b0;
        #6;
        for (int k = 0; k < n; k++) begin
            o_din = (k < 8) ? cmd[7-k] : ~o_din;
            #6 o_sclk = 1'b1;
            #6 o_sclk = 1'b0;
            // sampled on the falling edge, half a period after the device shifts
            if (k >= 7 && k < 55) o_word = {o_word[46:0], i_pin};
        end
        #6 o_din = ~o_din;
        o_cs_n = ~tw;
        if (rd) begin
            o_word_vld = 1'b1;
            #1 o_word_vld = 1'b0;
        end
    endtask
endmodule

// ---- testbench.sv ----
// self-checking bench for the converter control block with a host serial model
// assumes the host model drives the serial pins and reports each frame it reads
`timescale 1ns/10ps
module testbench;
    import adc_pkg::*;
    logic        i_clk, i_rst, i_clk_en, i_sclk, i_cs_n, i_din, i_start, i_reset_powerdown_pin_n;
    logic        i_xtal_det, i_ext_clk_det, i_overrange, i_ref_alarm, i_main_done, i_aux_en, i_aux_done;
    logic        i_oneshot, i_pga_bypass, word_vld;
    logic [31:0] i_main_result;
    logic [23:0] i_aux_result;
    logic [2:0]  i_gain, i_filter, i_aux_gain;
    logic [3:0]  i_rate, i_main_positive_input_field, i_main_negative_input_field;
    logic [3:0]  i_aux_positive_input_field, i_aux_negative_input_field;
    logic [7:0]  i_gpio_dir, i_gpio_out, i_gpio_pin;
    logic        o_serial_out_ready_pin, o_conversion_ready_n, o_converting, o_powerdown;
    logic        o_pga_bypass, o_filter_fallback;
    logic [1:0]  o_clk_source;
    logic [2:0]  o_pga_gain, o_filter, o_aux_gain;
    logic [3:0]  o_rate;
    logic [7:0]  o_main_input_select, o_aux_input_select, o_gpio_oe, o_gpio_drive, o_gpio_in;
    logic [47:0] word;
    logic [47:0] exp_q[$];
    logic [31:0] r1;
    logic        fb;
    int          error_cnt, compares, cyc_cnt;

    adc_ctrl u_dut (.i_clk, .i_rst, .i_clk_en, .i_sclk, .i_cs_n, .i_din, .i_start, .i_reset_powerdown_pin_n,
        .i_xtal_det, .i_ext_clk_det, .i_overrange, .i_ref_alarm, .i_main_done, .i_main_result, .i_aux_en,
        .i_aux_done, .i_aux_result, .i_oneshot, .i_gain, .i_pga_bypass, .i_filter, .i_rate, .i_aux_gain,
        .i_main_positive_input_field, .i_main_negative_input_field, .i_aux_positive_input_field,
        .i_aux_negative_input_field, .i_gpio_dir, .i_gpio_out, .i_gpio_pin, .o_serial_out_ready_pin,
        .o_conversion_ready_n, .o_converting, .o_powerdown, .o_clk_source, .o_pga_gain, .o_pga_bypass,
        .o_filter, .o_filter_fallback, .o_rate, .o_aux_gain, .o_main_input_select, .o_aux_input_select,
        .o_gpio_oe, .o_gpio_drive, .o_gpio_in);
    host_spi u_host (.i_pin(o_serial_out_ready_pin), .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_din(i_din),
        .o_word(word), .o_word_vld(word_vld));

    always #25 i_clk = ~i_clk;

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    always @(posedge i_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    always @(posedge word_vld) begin
        if (exp_q.size() == 0) check("frame queue", 48'h1, 48'h0);
        else check("frame", exp_q.pop_front(), word);
    end

    // inputs move 2 ns after the edge so the design samples settled values
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask

    function automatic logic [7:0] crc8(input logic [39:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int k = 39; k >= 0; k--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[k]) ? CRC_POLY : 8'h00);
        return c;
    endfunction

    function automatic logic pick(input int sel);
        return (sel == 0) ? o_conversion_ready_n : ((sel == 1) ? o_converting : o_powerdown);
    endfunction

    task automatic wait_sig(input int sel, input logic lvl, input string what);
        int k;
        k = 0;
        while (pick(sel) !== lvl && k < 40) begin
            tick(1);
            k++;
        end
        check(what, 48'(lvl), 48'(pick(sel)));
    endtask

    // nd back-to-back results; only the last one may be read
    task automatic convert(input logic aux, input int nd, input logic [7:0] st, input logic [7:0] rd,
                           input logic tw);
        logic [31:0] d;
        for (int k = 0; k < nd; k++) begin
            d = $urandom;
            i_main_result = d;
            i_aux_result = d[23:0];
            i_main_done = !aux;
            i_aux_done = aux;
            tick(1);
        end
        i_main_done = 1'b0;
        i_aux_done = 1'b0;
        if (!aux) begin
            wait_sig(0, 1'b0, "ready_n");
            check("ready pin", 48'h0, 48'(o_serial_out_ready_pin));
        end
        if (rd != 8'h00) begin
            tick(4);
            exp_q.push_back(aux ? {st, d[23:0], 8'h00, crc8({st, d[23:0], 8'h00})} : {st, d, crc8({st, d})});
            u_host.frame(rd, 1'b1, tw);
            tick(8);
            if (!aux) wait_sig(0, 1'b1, "ready_n after read");
        end
    endtask

    initial begin
        {i_clk, i_start, i_xtal_det, i_ext_clk_det, i_overrange, i_ref_alarm, i_main_done, i_aux_done} = '0;
        {i_aux_en, i_oneshot, i_gain, i_pga_bypass, i_filter, i_rate, i_aux_gain} = '0;
        {i_main_positive_input_field, i_main_negative_input_field} = 8'h00;
        {i_aux_positive_input_field, i_aux_negative_input_field} = 8'h00;
        {i_gpio_dir, i_gpio_out, i_gpio_pin, i_main_result, i_aux_result} = '0;
        i_clk_en = 1'b1;
        i_reset_powerdown_pin_n = 1'b1;
        i_rst = 1'b1;
        error_cnt = 0;
        compares = 0;
        cyc_cnt = 0;
        void'($urandom(32'h4d68083b));
        tick(5);
        check("reset idle", 48'h1_10, 48'({o_conversion_ready_n, 3'h0, o_serial_out_ready_pin, o_converting,
              o_powerdown, o_clk_source}));
        tick(5);
        i_rst = 1'b0;
        tick(3);
        for (int n = 0; n < 12; n++) begin
            r1 = $urandom;
            {i_pga_bypass, i_rate, i_aux_gain, i_main_positive_input_field, i_main_negative_input_field} = r1[15:0];
            {i_aux_positive_input_field, i_aux_negative_input_field} = r1[31:24];
            {i_gpio_dir, i_gpio_out, i_gpio_pin} = 24'($urandom);
            i_gain = 3'(n);
            i_filter = 3'(n);
            tick(4);
            fb = (i_filter > FLT_FIR) || (i_filter == FLT_FIR && i_rate > RATE_20SPS);
            check("gain", 48'((i_gain > GAIN_MAX) ? GAIN_MAX : i_gain), 48'(o_pga_gain));
            check("bypass", 48'(i_pga_bypass), 48'(o_pga_bypass));
            check("fallback", 48'(fb), 48'(o_filter_fallback));
            check("filter", 48'(fb ? FLT_SINC1 : i_filter), 48'(o_filter));
            check("rate", 48'(i_rate), 48'(o_rate));
            check("aux gain", 48'(i_aux_gain), 48'(o_aux_gain));
            check("main sel", 48'({i_main_positive_input_field, i_main_negative_input_field}),
                  48'(o_main_input_select));
            check("aux sel", 48'({i_aux_positive_input_field, i_aux_negative_input_field}),
                  48'(o_aux_input_select));
            check("gpio", 48'({i_gpio_dir, i_gpio_out & i_gpio_dir, i_gpio_pin}),
                  48'({o_gpio_oe, o_gpio_drive, o_gpio_in}));
        end
        // enable low must hold the last gain code, here 3 from the final pass
        i_clk_en = 1'b0;
        i_gain = 3'h6;
        tick(4);
        check("gain frozen", 48'h3, 48'(o_pga_gain));
        i_clk_en = 1'b1;
        for (int n = 0; n < 4; n++) begin
            {i_ext_clk_det, i_xtal_det} = 2'(n);
            tick(5);
            check("clk source", 48'(i_ext_clk_det ? CLK_EXT : (i_xtal_det ? CLK_XTAL : CLK_INT)),
                  48'(o_clk_source));
        end
        i_oneshot = 1'b1;
        i_start = 1'b1;
        tick(3);
        i_start = 1'b0;
        wait_sig(1, 1'b1, "pin start");
        i_overrange = 1'b1;
        tick(4);
        i_overrange = 1'b0;
        tick(4);
        convert(1'b0, 1, 8'h01, CMD_RD_MAIN, 1'b0);
        check("oneshot idle", 48'h0, 48'(o_converting));
        i_oneshot = 1'b0;
        i_aux_en = 1'b1;
        i_ref_alarm = 1'b1;
        u_host.frame(CMD_START, 1'b0, 1'b0);
        wait_sig(1, 1'b1, "command start");
        tick(4);
        convert(1'b0, 2, 8'h02, 8'h00, 1'b0);
        convert(1'b0, 1, 8'h02, CMD_RD_MAIN, 1'b1);
        convert(1'b0, 1, 8'h02, CMD_RD_MAIN, 1'b1);
        convert(1'b1, 1, 8'h02, CMD_RD_AUX, 1'b0);
        check("free run", 48'h1, 48'(o_converting));
        convert(1'b0, 1, 8'h02, 8'h00, 1'b0);
        u_host.frame(CMD_STOP, 1'b0, 1'b0);
        wait_sig(1, 1'b0, "command stop");
        i_ref_alarm = 1'b0;
        i_reset_powerdown_pin_n = 1'b0;
        tick(4);
        i_reset_powerdown_pin_n = 1'b1;
        tick(4);
        check("pulse reset", 48'h2, 48'({o_conversion_ready_n, o_powerdown}));
        i_reset_powerdown_pin_n = 1'b0;
        tick(PWDN_CYC + 6);
        check("held low", 48'h3, 48'({o_conversion_ready_n, o_powerdown}));
        i_reset_powerdown_pin_n = 1'b1;
        wait_sig(2, 1'b0, "power up");
        tick(4);
        close_out();
    end
endmodule
